//--- include/srtc_pkg.sv
/*
 * Shared constants and types of the serial calendar clock access port: command field codes,
 * bit positions, reset values, counter limits and serial timing counts.
 * Assumes a 25 MHz core clock on both ends and a 32.768 kHz crystal level on the device end.
 */
`default_nettype none

package srtc_pkg;

    // Core clock period and serial timing minimums in nanoseconds.
    localparam int CLK_NS = 40;
    localparam int SCLK_HALF_MIN_NS = 470;
    localparam int CE_SETUP_MIN_NS = 470;
    // Least times round up to whole core cycles.
    localparam int HALF_CYC = (SCLK_HALF_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int SETUP_CYC = (CE_SETUP_MIN_NS + CLK_NS - 1) / CLK_NS;

    // Crystal prescaler: one second is 32768 crystal periods.
    localparam logic [14:0] PRESC_LAST = 15'h7FFF;

    // Frame layout.
    localparam logic [4:0] CMD_LAST_BIT = 5'h03;
    localparam logic [3:0] FRAME_LAST_BIT = 4'hB;
    localparam logic [3:0] FIRST_DATA_BIT = 4'h4;
    localparam logic [3:0] BYTE_LEN = 4'h8;
    localparam logic [3:0] NIBBLE_LEN = 4'h4;
    localparam int CMD_RW_BIT = 0;
    localparam int MODE_FOUT_BIT = 7;
    localparam int DOW_FLAG_BIT = 3;

    // Field selects carried in command bits 3..1.
    localparam logic [2:0] SEL_MODE = 3'h0;
    localparam logic [2:0] SEL_YEAR = 3'h1;
    localparam logic [2:0] SEL_MONTH = 3'h2;
    localparam logic [2:0] SEL_DATE = 3'h3;
    localparam logic [2:0] SEL_DOW = 3'h4;
    localparam logic [2:0] SEL_HOUR = 3'h5;
    localparam logic [2:0] SEL_MIN = 3'h6;
    localparam logic [2:0] SEL_SEC = 3'h7;

    // BCD limits and reset values.
    localparam logic [7:0] MAX_SEC = 8'h59;
    localparam logic [7:0] MAX_HOUR = 8'h23;
    localparam logic [7:0] MAX_MONTH = 8'h12;
    localparam logic [7:0] MAX_YEAR = 8'h99;
    localparam logic [7:0] BCD_ZERO = 8'h00;
    localparam logic [7:0] BCD_ONE = 8'h01;
    localparam logic [2:0] DOW_FIRST = 3'h1;
    localparam logic [2:0] DOW_LAST = 3'h7;
    localparam logic [7:0] RST_MODE = 8'h00;

    // Calendar fields, all BCD except the weekday.
    typedef struct packed {
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
        logic [2:0] dow;
        logic [7:0] date;
        logic [7:0] month;
        logic [7:0] year;
    } srtc_cal_t;

    // Host sequencer states.
    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_SETUP = 3'b001,
        H_LOW = 3'b010,
        H_HIGH = 3'b011,
        H_TAIL = 3'b100,
        H_GAP = 3'b101
    } srtc_hst_state_t;

    // Steps a BCD counter, wrapping from top back to first.
    function automatic logic [7:0] bcd_step(input logic [7:0] v, input logic [7:0] top, input logic [7:0] first);
        if (v == top) begin
            return first;
        end else if (v[3:0] == 4'h9) begin
            return {v[7:4] + 4'h1, 4'h0};
        end else begin
            return {v[7:4], v[3:0] + 4'h1};
        end
    endfunction : bcd_step

endpackage : srtc_pkg

`default_nettype wire

//--- include/srtc_link_if.sv
/*
 * Three-wire link between host and clock device: chip enable, serial clock and one shared data line.
 * Assumes each end drives its data output only while its enable is high; an undriven line reads low.
 */
`default_nettype none

interface srtc_link_if;
    logic ce;
    logic sclk;
    logic host_dat;
    logic host_oe;
    logic dev_dat;
    logic dev_oe;
    logic dat_line;

    // Resolved level of the shared data line.
    assign dat_line = dev_oe ? dev_dat : (host_oe ? host_dat : 1'b0);

    modport host (output ce, output sclk, output host_dat, output host_oe, input dat_line);
    modport dev (input ce, input sclk, input dat_line, output dev_dat, output dev_oe);
endinterface : srtc_link_if

`default_nettype wire

//--- rtl/srtc_calendar.sv
/*
 * BCD calendar counter: seconds through year with month lengths and leap years, loadable per field.
 * Assumes a one-cycle tick per second and write strobes on the same core clock.
 */
`default_nettype none

module srtc_calendar (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic tick_i,
    input wire logic wr_en_i,
    input wire logic [2:0] wr_sel_i,
    input wire logic [7:0] wr_data_i,
    output srtc_pkg::srtc_cal_t cal_o
);

    srtc_pkg::srtc_cal_t cal_reg;
    srtc_pkg::srtc_cal_t cal_next;
    logic [7:0] month_end;

    // Last date of a month; years divisible by four are leap, valid for one century.
    function automatic logic [7:0] last_date(input logic [7:0] month, input logic [7:0] year);
        logic leap;
        leap = year[4] ? (year[3:0] == 4'h2 || year[3:0] == 4'h6)
                       : (year[3:0] == 4'h0 || year[3:0] == 4'h4 || year[3:0] == 4'h8);
        case (month)
            8'h02: return leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
            default: return 8'h31;
        endcase
    endfunction : last_date

    // Field loads take priority over the tick; the device holds the tick off while loading anyway.
    always_comb begin
        cal_next = cal_reg;
        month_end = last_date(cal_reg.month, cal_reg.year);
        if (rst_i) begin
            cal_next.sec = srtc_pkg::BCD_ZERO;
            cal_next.min = srtc_pkg::BCD_ZERO;
            cal_next.hour = srtc_pkg::BCD_ZERO;
            cal_next.dow = srtc_pkg::DOW_FIRST;
            cal_next.date = srtc_pkg::BCD_ONE;
            cal_next.month = srtc_pkg::BCD_ONE;
            cal_next.year = srtc_pkg::BCD_ZERO;
        end else if (wr_en_i) begin
            case (wr_sel_i)
                srtc_pkg::SEL_YEAR: cal_next.year = wr_data_i;
                srtc_pkg::SEL_MONTH: cal_next.month = wr_data_i;
                srtc_pkg::SEL_DATE: cal_next.date = wr_data_i;
                srtc_pkg::SEL_DOW: cal_next.dow = wr_data_i[2:0];
                srtc_pkg::SEL_HOUR: cal_next.hour = wr_data_i;
                srtc_pkg::SEL_MIN: cal_next.min = wr_data_i;
                srtc_pkg::SEL_SEC: cal_next.sec = wr_data_i;
                default: cal_next = cal_reg;
            endcase
        end else if (tick_i) begin
            cal_next.sec = srtc_pkg::bcd_step(cal_reg.sec, srtc_pkg::MAX_SEC, srtc_pkg::BCD_ZERO);
            if (cal_reg.sec == srtc_pkg::MAX_SEC) begin
                cal_next.min = srtc_pkg::bcd_step(cal_reg.min, srtc_pkg::MAX_SEC, srtc_pkg::BCD_ZERO);
                if (cal_reg.min == srtc_pkg::MAX_SEC) begin
                    cal_next.hour = srtc_pkg::bcd_step(cal_reg.hour, srtc_pkg::MAX_HOUR, srtc_pkg::BCD_ZERO);
                    if (cal_reg.hour == srtc_pkg::MAX_HOUR) begin
                        cal_next.dow = (cal_reg.dow == srtc_pkg::DOW_LAST) ? srtc_pkg::DOW_FIRST
                                                                           : cal_reg.dow + 3'h1;
                        cal_next.date = srtc_pkg::bcd_step(cal_reg.date, month_end, srtc_pkg::BCD_ONE);
                        if (cal_reg.date == month_end) begin
                            cal_next.month = srtc_pkg::bcd_step(cal_reg.month, srtc_pkg::MAX_MONTH,
                                                                srtc_pkg::BCD_ONE);
                            if (cal_reg.month == srtc_pkg::MAX_MONTH) begin
                                cal_next.year = srtc_pkg::bcd_step(cal_reg.year, srtc_pkg::MAX_YEAR,
                                                                   srtc_pkg::BCD_ZERO);
                            end
                        end
                    end
                end
            end
        end
    end

    // State register.
    always_ff @(posedge core_clk_i) begin
        cal_reg <= cal_next;
    end

    assign cal_o = cal_reg;

endmodule : srtc_calendar

`default_nettype wire

//--- rtl/srtc_dev_end.sv
/*
 * Device end of the serial calendar clock: serial command and data shifting on the link clock,
 * timekeeping, write commit, low-supply flag and the crystal output pin on the core clock.
 * Assumes the host keeps the serial clock low around chip enable edges and leaves the serial
 * clock idle while chip enable is low, so the shifted command and data stay still between frames.
 */

`default_nettype none

module srtc_dev_end (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic xtal_i,
    input wire logic low_supply_i,
    output logic fout_o,
    output logic fout_oe_o,
    output logic [7:0] mode_o,
    output logic low_supply_flag_o,
    output srtc_pkg::srtc_cal_t cal_o,
    srtc_link_if.dev lnk
);

    // Link control on the serial rising edge, cleared while chip enable is low.
    typedef struct packed {
        logic [4:0] cnt;
        logic wr_mode;
        logic rd_mode;
    } srtc_lctl_t;

    // Shifted command and data; no clear, so the core can read them after the frame.
    typedef struct packed {
        logic [3:0] cmd;
        logic [7:0] dat;
    } srtc_ldat_t;

    // Read driver on the serial falling edge.
    typedef struct packed {
        logic drive;
        logic [3:0] idx;
        logic dout;
    } srtc_ldrv_t;

    // Core-domain state.
    typedef struct packed {
        logic ce_s1;
        logic ce_s2;
        logic ce_s3;
        logic wm_s1;
        logic wm_s2;
        logic xt_s1;
        logic xt_s2;
        logic xt_s3;
        logic lo_s1;
        logic lo_s2;
        logic [14:0] presc;
        logic pend;
        logic [7:0] mode;
        logic flag;
        logic snap_flag;
        srtc_pkg::srtc_cal_t snap;
    } srtc_core_t;

    srtc_lctl_t lctl_reg;
    srtc_lctl_t lctl_next;
    srtc_ldat_t ldat_reg;
    srtc_ldat_t ldat_next;
    srtc_ldrv_t ldrv_reg;
    srtc_ldrv_t ldrv_next;
    srtc_core_t core_reg;
    srtc_core_t core_next;
    srtc_pkg::srtc_cal_t cal;
    logic [2:0] wr_sel;
    logic [7:0] wr_data;
    logic [7:0] rd_word;
    logic [3:0] rd_len;
    logic time_frozen;
    logic sec_pulse;
    logic tick;
    logic commit;

    // Selects the read word for a field from the frozen snapshot.
    function automatic logic [7:0] read_field(input srtc_pkg::srtc_cal_t s, input logic flg, input logic [2:0] sel);
        case (sel)
            srtc_pkg::SEL_YEAR: return s.year;
            srtc_pkg::SEL_MONTH: return s.month;
            srtc_pkg::SEL_DATE: return s.date;
            srtc_pkg::SEL_DOW: return {4'h0, flg, s.dow};
            srtc_pkg::SEL_HOUR: return s.hour;
            srtc_pkg::SEL_MIN: return s.min;
            srtc_pkg::SEL_SEC: return s.sec;
            default: return 8'h00;
        endcase
    endfunction : read_field

    // Command decode at the fourth rising edge; later bits never touch the command.
    always_comb begin
        lctl_next = lctl_reg;
        if (lctl_reg.cnt != 5'h1F) begin
            lctl_next.cnt = lctl_reg.cnt + 5'h01;
        end
        if (lctl_reg.cnt == srtc_pkg::CMD_LAST_BIT) begin
            lctl_next.wr_mode = ldat_reg.cmd[srtc_pkg::CMD_RW_BIT];
            lctl_next.rd_mode = !ldat_reg.cmd[srtc_pkg::CMD_RW_BIT]
                                && ({lnk.dat_line, ldat_reg.cmd[2:0]} != 4'h0);
        end
    end

    // Chip enable low clears the frame; rising edges shift the line in.
    always_ff @(posedge lnk.sclk or negedge lnk.ce) begin
        if (!lnk.ce) begin
            lctl_reg <= '0;
        end else begin
            lctl_reg <= lctl_next;
        end
    end

    // First four bits fill the command LSB first; all later bits shift the data LSB first.
    always_comb begin
        ldat_next = ldat_reg;
        if (lctl_reg.cnt <= srtc_pkg::CMD_LAST_BIT) begin
            ldat_next.cmd[lctl_reg.cnt[1:0]] = lnk.dat_line;
        end else begin
            ldat_next.dat = {lnk.dat_line, ldat_reg.dat[7:1]};
        end
    end

    // Data shift register runs only while the frame is open.
    always_ff @(posedge lnk.sclk) begin
        if (lnk.ce) begin
            ldat_reg <= ldat_next;
        end
    end

    // The snapshot is frozen while chip enable is high, so the serial domain reads a still word.
    assign rd_word = read_field(core_reg.snap, core_reg.snap_flag, ldat_reg.cmd[3:1]);
    assign rd_len = (ldat_reg.cmd[3:1] == srtc_pkg::SEL_DOW) ? srtc_pkg::NIBBLE_LEN : srtc_pkg::BYTE_LEN;

    // Falling edges after a read command turn the line round and shift the word out.
    always_comb begin
        ldrv_next = ldrv_reg;
        if (lctl_reg.rd_mode) begin
            ldrv_next.drive = 1'b1;
            ldrv_next.dout = (ldrv_reg.idx < rd_len) ? rd_word[ldrv_reg.idx[2:0]] : 1'b0;
            if (ldrv_reg.idx != 4'hF) begin
                ldrv_next.idx = ldrv_reg.idx + 4'h1;
            end
        end
    end

    // Read driver register, cleared as soon as chip enable drops.
    always_ff @(negedge lnk.sclk or negedge lnk.ce) begin
        if (!lnk.ce) begin
            ldrv_reg <= '0;
        end else begin
            ldrv_reg <= ldrv_next;
        end
    end

    // The enable is gated by the pin itself so the line frees at once, without a clock edge.
    assign lnk.dev_oe = lnk.ce && ldrv_reg.drive;
    assign lnk.dev_dat = ldrv_reg.dout;

    // Write field and value, read only once the frame has ended and the link clock is still.
    assign wr_sel = ldat_reg.cmd[3:1];
    assign wr_data = (wr_sel == srtc_pkg::SEL_DOW) ? {4'h0, ldat_reg.dat[7:4]} : ldat_reg.dat;
    assign time_frozen = core_reg.pend && (wr_sel != srtc_pkg::SEL_MODE);
    assign commit = core_reg.pend && core_reg.ce_s3 && !core_reg.ce_s2;
    assign sec_pulse = core_reg.xt_s2 && !core_reg.xt_s3 && (core_reg.presc == srtc_pkg::PRESC_LAST);
    assign tick = sec_pulse && !time_frozen;

    // Core next state: synchronisers, prescaler, write commit, flag and snapshot.
    always_comb begin
        core_next = core_reg;
        core_next.ce_s1 = lnk.ce;
        core_next.ce_s2 = core_reg.ce_s1;
        core_next.ce_s3 = core_reg.ce_s2;
        core_next.wm_s1 = lctl_reg.wr_mode;
        core_next.wm_s2 = core_reg.wm_s1;
        core_next.xt_s1 = xtal_i;
        core_next.xt_s2 = core_reg.xt_s1;
        core_next.xt_s3 = core_reg.xt_s2;
        core_next.lo_s1 = low_supply_i;
        core_next.lo_s2 = core_reg.lo_s1;
        if (time_frozen) begin
            core_next.presc = 15'h0000;
        end else if (core_reg.xt_s2 && !core_reg.xt_s3) begin
            core_next.presc = core_reg.presc + 15'h0001;
        end
        if (core_reg.wm_s2) begin
            core_next.pend = 1'b1;
        end
        if (commit) begin
            core_next.pend = 1'b0;
            core_next.flag = 1'b0;
            if (wr_sel == srtc_pkg::SEL_MODE) begin
                core_next.mode = ldat_reg.dat;
            end
        end
        // A check landing on a write commit keeps the warning.
        if (sec_pulse && core_reg.lo_s2) begin
            core_next.flag = 1'b1;
        end
        if (!core_reg.ce_s2) begin
            core_next.snap = cal;
            core_next.snap_flag = core_reg.flag;
        end
        if (rst_i) begin
            core_next = '0;
            core_next.mode = srtc_pkg::RST_MODE;
            core_next.flag = 1'b0;
        end
    end

    // Core state register.
    always_ff @(posedge core_clk_i) begin
        core_reg <= core_next;
    end

    srtc_calendar u_cal (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .tick_i(tick),
        .wr_en_i(commit && (wr_sel != srtc_pkg::SEL_MODE)),
        .wr_sel_i(wr_sel),
        .wr_data_i(wr_data),
        .cal_o(cal)
    );

    // Crystal output follows the synchronised crystal level while enabled.
    assign fout_o = core_reg.xt_s2;
    assign fout_oe_o = core_reg.mode[srtc_pkg::MODE_FOUT_BIT];
    assign mode_o = core_reg.mode;
    assign low_supply_flag_o = core_reg.flag;
    assign cal_o = cal;

endmodule : srtc_dev_end

`default_nettype wire

//--- rtl/srtc_host_end.sv
/*
 * Host end of the serial calendar clock link: runs one read or write frame per command,
 * making the serial clock by dividing the core clock.
 * Assumes a device that drives read bits from the falling serial edge after the command.
 */
`default_nettype none

module srtc_host_end (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic cmd_valid_i,
    output logic cmd_ready_o,
    input wire logic cmd_write_i,
    input wire logic [2:0] cmd_sel_i,
    input wire logic [7:0] cmd_wdata_i,
    output logic rsp_valid_o,
    output logic [7:0] rsp_data_o,
    srtc_link_if.host lnk
);

    typedef struct packed {
        srtc_pkg::srtc_hst_state_t st;
        logic [7:0] tmr;
        logic [3:0] bit_i;
        logic [11:0] word;
        logic rd;
        logic ce;
        logic sclk;
        logic dat;
        logic oe;
        logic [7:0] rx;
        logic d_s1;
        logic d_s2;
        logic rsp_v;
        logic [7:0] rsp_d;
    } srtc_host_t;

    srtc_host_t h_reg;
    srtc_host_t h_next;
    logic [3:0] nb;

    // One frame is always twelve clocks; reads discard what follows the valid bits.
    always_comb begin
        h_next = h_reg;
        nb = h_reg.bit_i + 4'h1;
        h_next.d_s1 = lnk.dat_line;
        h_next.d_s2 = h_reg.d_s1;
        h_next.rsp_v = 1'b0;
        if (h_reg.tmr != 8'h00) begin
            h_next.tmr = h_reg.tmr - 8'h01;
        end
        case (h_reg.st)
            srtc_pkg::H_IDLE: begin
                if (cmd_valid_i) begin
                    h_next.word = {cmd_write_i ? ((cmd_sel_i == srtc_pkg::SEL_DOW) ? {cmd_wdata_i[3:0], 4'h0}
                                                                                  : cmd_wdata_i) : 8'h00,
                                   cmd_sel_i, cmd_write_i};
                    h_next.rd = !cmd_write_i;
                    h_next.ce = 1'b1;
                    h_next.oe = 1'b1;
                    h_next.dat = cmd_write_i;
                    h_next.bit_i = 4'h0;
                    h_next.tmr = 8'(srtc_pkg::SETUP_CYC - 1);
                    h_next.st = srtc_pkg::H_SETUP;
                end
            end
            srtc_pkg::H_SETUP: begin
                if (h_reg.tmr == 8'h00) begin
                    h_next.tmr = 8'(srtc_pkg::HALF_CYC - 1);
                    h_next.st = srtc_pkg::H_LOW;
                end
            end
            srtc_pkg::H_LOW: begin
                if (h_reg.tmr == 8'h00) begin
                    if (h_reg.rd && h_reg.bit_i >= srtc_pkg::FIRST_DATA_BIT) begin
                        h_next.rx = {h_reg.d_s2, h_reg.rx[7:1]};
                    end
                    h_next.sclk = 1'b1;
                    h_next.tmr = 8'(srtc_pkg::HALF_CYC - 1);
                    h_next.st = srtc_pkg::H_HIGH;
                end
            end
            srtc_pkg::H_HIGH: begin
                if (h_reg.tmr == 8'h00) begin
                    h_next.sclk = 1'b0;
                    h_next.tmr = 8'(srtc_pkg::HALF_CYC - 1);
                    if (h_reg.bit_i == srtc_pkg::FRAME_LAST_BIT) begin
                        h_next.st = srtc_pkg::H_TAIL;
                    end else begin
                        h_next.bit_i = nb;
                        h_next.dat = h_reg.word[nb];
                        h_next.oe = !(h_reg.rd && nb >= srtc_pkg::FIRST_DATA_BIT);
                        h_next.st = srtc_pkg::H_LOW;
                    end
                end
            end
            srtc_pkg::H_TAIL: begin
                if (h_reg.tmr == 8'h00) begin
                    h_next.ce = 1'b0;
                    h_next.oe = 1'b0;
                    h_next.tmr = 8'(srtc_pkg::HALF_CYC - 1);
                    h_next.st = srtc_pkg::H_GAP;
                end
            end
            srtc_pkg::H_GAP: begin
                if (h_reg.tmr == 8'h00) begin
                    // One field per answer; a caller joining fields must allow for a carry between frames.
                    h_next.rsp_v = 1'b1;
                    h_next.rsp_d = !h_reg.rd ? 8'h00
                                 : (h_reg.word[3:1] == srtc_pkg::SEL_DOW) ? {4'h0, h_reg.rx[3:0]} : h_reg.rx;
                    h_next.st = srtc_pkg::H_IDLE;
                end
            end
            default: h_next.st = srtc_pkg::H_IDLE;
        endcase
        if (rst_i) begin
            h_next = '0;
            h_next.st = srtc_pkg::H_IDLE;
        end
    end

    // State register.
    always_ff @(posedge core_clk_i) begin
        h_reg <= h_next;
    end

    assign cmd_ready_o = (h_reg.st == srtc_pkg::H_IDLE);
    assign rsp_valid_o = h_reg.rsp_v;
    assign rsp_data_o = h_reg.rsp_d;
    assign lnk.ce = h_reg.ce;
    assign lnk.sclk = h_reg.sclk;
    assign lnk.host_dat = h_reg.dat;
    assign lnk.host_oe = h_reg.oe;

endmodule : srtc_host_end

`default_nettype wire

//--- tb/srtc_link_assertions.sv
/* Checker on the link between the two ends of the serial clock port.
   Assumes the host paces the serial clock from the core clock, so one clock samples all. */
`default_nettype none
module srtc_link_chk (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic ce,
    input wire logic sclk,
    input wire logic host_dat,
    input wire logic host_oe,
    input wire logic dev_dat,
    input wire logic dev_oe,
    input wire logic dat_line
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    logic [4:0] rise_cnt;
    // Serial rises in the open frame; the count is only meaningful at the closing edge.
    always_ff @(posedge core_clk_i) begin
        if (rst_i || !ce) rise_cnt <= 5'h00;
        else if ($rose(sclk)) rise_cnt <= rise_cnt + 5'h01;
    end
    one_driver_a: assert property (!(host_oe && dev_oe)) else $error("both ends drive data");
    dev_release_a: assert property (dev_oe |-> ce) else $error("device drives outside frame");
    ce_edge_a: assert property ($changed(ce) |-> !sclk) else $error("enable moved with clock high");
    sclk_idle_a: assert property (!ce |-> !sclk) else $error("serial clock runs outside frame");
    drive_start_a: assert property ($rose(dev_oe) |-> $fell(sclk) && !host_oe) else $error("bad turnaround");
    read_shift_a: assert property (dev_oe && $past(dev_oe) && $changed(dev_dat) |-> $fell(sclk))
        else $error("read bit moved off falling edge");
    frame_bits_a: assert property ($fell(ce) |-> rise_cnt == 5'h0C) else $error("frame not twelve bits");
    drive_stop_a: assert property ($fell(dev_oe) |-> !ce) else $error("device let go early");
    idle_line_a: assert property (!ce |-> !dat_line) else $error("data line busy when idle");
    cover property ($rose(dev_oe));
    cover property ($fell(ce) && $past(dev_oe));
    cover property ($fell(ce) && $past(host_oe) && host_dat == 1'b0);
endmodule : srtc_link_chk
`default_nettype wire

//--- tb/tb_serial_rtc_access_port.sv
/* Bench joining host and device ends of the serial clock port through the link interface.
   Assumes a crystal far too slow for a seconds tick within the run, so calendar stays put. */
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; $display("BAD %s exp %h got %h", n, e, g); end end
module tb_serial_rtc_access_port;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic wr; logic [2:0] sel; logic [7:0] d; logic [7:0] exp;} srtc_row_t;
    logic core_clk_i = 1'b0, rst_i = 1'b1, cmd_valid_i = 1'b0, cmd_write_i = 1'b0;
    logic xtal_i = 1'b0, low_supply_i = 1'b0;
    logic [2:0] cmd_sel_i = 3'h0;
    logic [7:0] cmd_wdata_i = 8'h00, q, rsp_data_o, mode_o;
    logic cmd_ready_o, rsp_valid_o, fout_o, fout_oe_o, low_supply_flag_o;
    srtc_pkg::srtc_cal_t cal_o;
    int error_cnt = 0, total_checks = 0, cyc = 0;
    // Writes answer zero; the mode read is the all-zero command and must stay undriven.
    srtc_row_t rows [12] = '{'{1, 3'h7, 8'h30, 8'h00}, '{0, 3'h7, 8'h00, 8'h30}, '{1, 3'h6, 8'h59, 8'h00},
        '{0, 3'h6, 8'h00, 8'h59}, '{1, 3'h5, 8'h23, 8'h00}, '{0, 3'h5, 8'h00, 8'h23},
        '{1, 3'h4, 8'h0D, 8'h00}, '{0, 3'h4, 8'h00, 8'h05}, '{1, 3'h1, 8'h99, 8'h00},
        '{0, 3'h1, 8'h00, 8'h99}, '{1, 3'h0, 8'h80, 8'h00}, '{0, 3'h0, 8'h00, 8'h00}};
    srtc_link_if lnk ();
    srtc_host_end srtc_host_end_i (.core_clk_i, .rst_i, .cmd_valid_i, .cmd_ready_o, .cmd_write_i, .cmd_sel_i,
        .cmd_wdata_i, .rsp_valid_o, .rsp_data_o, .lnk(lnk));
    srtc_dev_end srtc_dev_end_i (.core_clk_i, .rst_i, .xtal_i, .low_supply_i, .fout_o, .fout_oe_o, .mode_o,
        .low_supply_flag_o, .cal_o, .lnk(lnk));
    srtc_link_chk srtc_link_chk_i (.core_clk_i, .rst_i, .ce(lnk.ce), .sclk(lnk.sclk), .host_dat(lnk.host_dat),
        .host_oe(lnk.host_oe), .dev_dat(lnk.dev_dat), .dev_oe(lnk.dev_oe), .dat_line(lnk.dat_line));
    // Core clock and a slow crystal, five core cycles per half period.
    always #20 core_clk_i = ~core_clk_i;
    always #200 xtal_i = ~xtal_i;
    // A frame takes about 330 cycles, so this ceiling only trips on a hang.
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            wrap_up();
        end
    end
    task automatic wrap_up;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : wrap_up
    // Runs one frame and returns the answer; valid is held for the single taking edge.
    task automatic run(input srtc_row_t r, output logic [7:0] v);
        cmd_write_i = r.wr;
        cmd_sel_i = r.sel;
        cmd_wdata_i = r.d;
        cmd_valid_i = 1'b1;
        @(posedge core_clk_i) #1;
        cmd_valid_i = 1'b0;
        while (rsp_valid_o !== 1'b1) @(posedge core_clk_i) #1;
        v = rsp_data_o;
        @(posedge core_clk_i) #1;
    endtask : run
    initial begin
        repeat (20) @(posedge core_clk_i);
        #1 rst_i = 1'b0;
        `CHK("mode", 8'h00, mode_o)
        `CHK("dow", 3'h1, cal_o.dow)
        `CHK("flag", 1'b0, low_supply_flag_o)
        foreach (rows[i]) begin
            run(rows[i], q);
            `CHK("rsp", rows[i].exp, q)
        end
        `CHK("fout_oe", 1'b1, fout_oe_o)
        `CHK("mode", 8'h80, mode_o)
        `CHK("sec", 8'h30, cal_o.sec)
        `CHK("year", 8'h99, cal_o.year)
        `CHK("dow_cal", 3'h5, cal_o.dow)
        // The crystal output follows the crystal level two core cycles late.
        @(posedge xtal_i);
        repeat (3) @(posedge core_clk_i);
        #1 `CHK("fout_hi", 1'b1, fout_o)
        @(negedge xtal_i);
        repeat (3) @(posedge core_clk_i);
        #1 `CHK("fout_lo", 1'b0, fout_o)
        // Mid-run reset must bring back the power-on values.
        rst_i = 1'b1;
        repeat (2) @(posedge core_clk_i);
        #1 rst_i = 1'b0;
        `CHK("mode_rst", 8'h00, mode_o)
        `CHK("fout_oe_rst", 1'b0, fout_oe_o)
        `CHK("flag_rst", 1'b0, low_supply_flag_o)
        `CHK("sec_rst", 8'h00, cal_o.sec)
        // Supply low, but no second has passed yet, so the weekday read shows a clear flag.
        low_supply_i = 1'b1;
        run('{0, 3'h4, 8'h00, 8'h01}, q);
        `CHK("dow_lo", 8'h01, q)
        wrap_up();
    end
endmodule : tb_serial_rtc_access_port
`undef CHK
`default_nettype wire
